// ==== core/dao_consts.svh ====
// Constants for the operand addressing block: register offsets,
// field positions, reset values and opcode field layout.
// Assumes inclusion by bare name from the design module and the testbench.
`ifndef DAO_CONSTS_SVH
`define DAO_CONSTS_SVH

// Register byte offsets on the APB slave
`define DAO_OFF_CTRL 8'h00
`define DAO_OFF_INDEX 8'h04
`define DAO_OFF_WORD2 8'h08
`define DAO_OFF_OPCODE 8'h0C
`define DAO_OFF_RESULT 8'h10
`define DAO_OFF_TARGET 8'h14
`define DAO_OFF_LITERAL 8'h18

// Control register fields
`define DAO_CTRL_BANK_MSB 3
`define DAO_CTRL_XEN_BIT 8

// Result register fields
`define DAO_RES_ADDR_MSB 11
`define DAO_RES_MODE_LSB 12
`define DAO_RES_MODE_MSB 14
`define DAO_RES_DEST_LSB 16
`define DAO_RES_DEST_MSB 17
`define DAO_RES_OK_BIT 18
`define DAO_RES_ADDR2_LSB 20
`define DAO_RES_ADDR2_MSB 31

// Opcode field positions
`define DAO_OP_A_BIT 8
`define DAO_OP_D_BIT 9

// Opcode group codes in the top nibble, row codes in the next nibble
`define DAO_GRP_MISC 4'h0
`define DAO_GRP_BYTE_LO 4'h1
`define DAO_GRP_BYTE_HI 4'h5
`define DAO_GRP_NOD 4'h6
`define DAO_GRP_BIT_LO 4'h7
`define DAO_GRP_BIT_HI 4'hB
`define DAO_GRP_MOVE 4'hC
`define DAO_GRP_BRANCH 4'hD
`define DAO_GRP_JUMP 4'hE
`define DAO_ROW_NONE 4'h0
`define DAO_ROW_BANKLD 4'h1
`define DAO_ROW_LIT 4'h8
`define DAO_ROW_CALL 4'hC
`define DAO_ROW_GOTO 4'hF

// Access bank halves and default split point
`define DAO_GPR_BANK 4'h0
`define DAO_SFR_BANK 4'hF
`define DAO_SPLIT_DEF 8'h60

// Reset value of every register
`define DAO_RST_ZERO 32'h0000_0000

`endif

// ==== core/dao_pkg.sv ====
// Types of the operand addressing block.
// Assumes dao_consts.svh sits on the include path.
package dao_pkg;

	// How the operand is found
	typedef enum logic [2:0] {
		DAO_M_INHERENT,
		DAO_M_LITERAL,
		DAO_M_BANKED,
		DAO_M_ACCESS,
		DAO_M_FULL,
		DAO_M_INDEXED
	} dao_mode_e;

	// Where the result goes
	typedef enum logic [1:0] {
		DAO_D_NONE,
		DAO_D_FILE,
		DAO_D_ACCUM
	} dao_dest_e;

	// One decoded instruction
	typedef struct packed {
		dao_mode_e mode;
		dao_dest_e dest;
		logic [11:0] addr;
		logic [11:0] addr2;
		logic addr_ok;
		logic [7:0] lit;
		logic [19:0] target;
	} dao_dec_s;

	// Whole state of the block
	typedef struct packed {
		logic [3:0] bank;
		logic xen;
		logic [11:0] idx;
		logic [15:0] w2;
		logic [15:0] op;
		dao_dec_s dec;
		logic strobe;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} dao_state_s;

endpackage

// ==== core/dao_addr.sv ====
// Operand address generation for an 8-bit core, with an APB slave.
// Assumes a zero-latency APB master on pclk and a data memory that
// takes the decoded address and destination from dec_out.
`include "dao_consts.svh"

module dao_addr #(
	parameter logic [7:0] SPLIT = `DAO_SPLIT_DEF
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output dao_pkg::dao_dec_s dec_out,
	output logic decode_strobe
);
	import dao_pkg::*;

	// Registered state and its next value
	dao_state_s s;
	dao_state_s next_s;
	// Completed write and setup-phase qualifiers
	logic wr_acc;
	logic setup;

	// Maps an 8-bit address into the access bank halves
	function automatic logic [11:0] dao_access_map(
		input logic [7:0] f,
		input logic [7:0] split
	);
		// Low part is general RAM, high part special registers
		if (f < split) begin
			return {`DAO_GPR_BANK, f};
		end
		return {`DAO_SFR_BANK, f};
	endfunction

	// Direct operand: banked, access bank or indexed
	function automatic dao_dec_s dao_direct(
		input logic [15:0] op,
		input logic [3:0] bank,
		input logic [11:0] idx,
		input logic xen,
		input logic [7:0] split
	);
		dao_dec_s r;
		r = '0;
		r.addr_ok = 1'b1;
		// Low byte is the file address, or the offset added to the index in indexed mode
		if (op[`DAO_OP_A_BIT]) begin
			// Bank pointer forms the upper nibble
			r.mode = DAO_M_BANKED;
			r.addr = {bank, op[7:0]};
		end else if (xen && (op[7:0] < split)) begin
			// Extension reinterprets low access addresses
			r.mode = DAO_M_INDEXED;
			r.addr = idx + {4'h0, op[7:0]};
		end else begin
			// Bank pointer plays no part here
			r.mode = DAO_M_ACCESS;
			r.addr = dao_access_map(op[7:0], split);
		end
		return r;
	endfunction

	// Full decode of one instruction
	function automatic dao_dec_s dao_decode(
		input logic [15:0] op,
		input logic [15:0] w2,
		input logic [3:0] bank,
		input logic [11:0] idx,
		input logic xen,
		input logic [7:0] split
	);
		dao_dec_s r;
		logic [3:0] grp;
		logic [3:0] row;
		r = '0;
		grp = op[15:12];
		row = op[11:8];
		case (grp)
			`DAO_GRP_MISC: begin
				if (row == `DAO_ROW_NONE) begin
					// Control ops with no operand
					r.mode = DAO_M_INHERENT;
				end else if (row == `DAO_ROW_BANKLD) begin
					// Literal that loads the bank pointer
					r.mode = DAO_M_LITERAL;
					r.lit = op[7:0];
				end else if (row < `DAO_ROW_LIT) begin
					// Byte op with destination bit
					r = dao_direct(op, bank, idx, xen, split);
					r.dest = op[`DAO_OP_D_BIT] ? DAO_D_FILE : DAO_D_ACCUM;
				end else begin
					// Constant into the accumulator
					r.mode = DAO_M_LITERAL;
					r.lit = op[7:0];
					r.dest = DAO_D_ACCUM;
				end
			end
			`DAO_GRP_NOD: begin
				// Byte op without destination bit writes the file
				r = dao_direct(op, bank, idx, xen, split);
				r.dest = DAO_D_FILE;
			end
			`DAO_GRP_MOVE: begin
				// Both addresses whole, bank pointer unused
				r.mode = DAO_M_FULL;
				r.addr = op[11:0];
				r.addr2 = w2[11:0];
				r.addr_ok = 1'b1;
				r.dest = DAO_D_FILE;
			end
			`DAO_GRP_BRANCH: begin
				// Relative branch offset goes to the program counter
				r.mode = DAO_M_LITERAL;
				r.lit = op[7:0];
			end
			`DAO_GRP_JUMP: begin
				r.mode = DAO_M_LITERAL;
				r.lit = op[7:0];
				if ((row == `DAO_ROW_CALL) || (row == `DAO_ROW_GOTO)) begin
					// Two-word 20-bit target
					r.target = {w2[11:0], op[7:0]};
				end
			end
			default: begin
				if ((grp >= `DAO_GRP_BYTE_LO) && (grp <= `DAO_GRP_BYTE_HI)) begin
					// Byte op with destination bit
					r = dao_direct(op, bank, idx, xen, split);
					r.dest = op[`DAO_OP_D_BIT] ? DAO_D_FILE : DAO_D_ACCUM;
				end else if ((grp >= `DAO_GRP_BIT_LO) && (grp <= `DAO_GRP_BIT_HI)) begin
					// Bit ops act on the addressed register
					r = dao_direct(op, bank, idx, xen, split);
					r.dest = DAO_D_FILE;
				end else begin
					// Second word seen alone: acts as no-operation
					r.mode = DAO_M_INHERENT;
				end
			end
		endcase
		return r;
	endfunction

	// Bus qualifiers
	assign wr_acc = psel && penable && s.pready && pwrite;
	assign setup = psel && !penable;

	// Next-state logic: bus slave and decode
	always_comb begin
		next_s = s;
		next_s.strobe = 1'b0;
		next_s.pready = 1'b0;
		next_s.pslverr = 1'b0;
		// Setup phase: prepare answer for the access phase
		if (setup) begin
			next_s.pready = 1'b1;
			next_s.prdata = `DAO_RST_ZERO;
			case (paddr)
				`DAO_OFF_CTRL: begin
					next_s.prdata[`DAO_CTRL_BANK_MSB:0] = s.bank;
					next_s.prdata[`DAO_CTRL_XEN_BIT] = s.xen;
				end
				`DAO_OFF_INDEX: begin
					next_s.prdata[11:0] = s.idx;
				end
				`DAO_OFF_WORD2: begin
					next_s.prdata[15:0] = s.w2;
				end
				`DAO_OFF_OPCODE: begin
					next_s.prdata[15:0] = s.op;
				end
				`DAO_OFF_RESULT: begin
					// Decoded address, mode and destination
					next_s.prdata[`DAO_RES_ADDR_MSB:0] = s.dec.addr;
					next_s.prdata[`DAO_RES_MODE_MSB:`DAO_RES_MODE_LSB] = s.dec.mode;
					next_s.prdata[`DAO_RES_DEST_MSB:`DAO_RES_DEST_LSB] = s.dec.dest;
					next_s.prdata[`DAO_RES_OK_BIT] = s.dec.addr_ok;
					next_s.prdata[`DAO_RES_ADDR2_MSB:`DAO_RES_ADDR2_LSB] = s.dec.addr2;
				end
				`DAO_OFF_TARGET: begin
					next_s.prdata[19:0] = s.dec.target;
				end
				`DAO_OFF_LITERAL: begin
					next_s.prdata[7:0] = s.dec.lit;
				end
				default: begin
					// Unmapped offset answers with an error
					next_s.pslverr = 1'b1;
				end
			endcase
		end
		// Access phase: writes take effect here
		if (wr_acc) begin
			case (paddr)
				`DAO_OFF_CTRL: begin
					next_s.bank = pwdata[`DAO_CTRL_BANK_MSB:0];
					next_s.xen = pwdata[`DAO_CTRL_XEN_BIT];
				end
				`DAO_OFF_INDEX: begin
					next_s.idx = pwdata[11:0];
				end
				`DAO_OFF_WORD2: begin
					next_s.w2 = pwdata[15:0];
				end
				`DAO_OFF_OPCODE: begin
					// Opcode write launches one decode
					next_s.op = pwdata[15:0];
					next_s.dec = dao_decode(pwdata[15:0], s.w2, s.bank, s.idx, s.xen, SPLIT);
					next_s.strobe = 1'b1;
				end
				default: begin
					// Read-only or unmapped: write ignored
					next_s.strobe = 1'b0;
				end
			endcase
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// Outputs straight from the state
	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign dec_out = s.dec;
	assign decode_strobe = s.strobe;

	// Checks on the decoded result, the decode strobe and the bus ready
	default clocking dao_cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// Strobe follows an opcode write by one cycle
	strobe_follow_a: assert property (
		(wr_acc && (paddr == `DAO_OFF_OPCODE)) |=> decode_strobe ##1 !decode_strobe
	) else $error("decode strobe not a one-cycle pulse");

	// Indexed mode only with extension enabled
	idx_gate_a: assert property (
		(decode_strobe && (s.dec.mode == DAO_M_INDEXED)) |-> s.xen
	) else $error("indexed mode without extension");

	// Banked address carries the bank pointer
	bank_addr_a: assert property (
		(decode_strobe && (s.dec.mode == DAO_M_BANKED))
		|-> (s.dec.addr == {s.bank, s.op[7:0]}) && s.op[`DAO_OP_A_BIT]
	) else $error("banked address wrong");

	// Access address ignores the bank pointer
	access_map_a: assert property (
		(decode_strobe && (s.dec.mode == DAO_M_ACCESS))
		|-> (s.dec.addr == dao_access_map(s.op[7:0], SPLIT)) && !s.op[`DAO_OP_A_BIT]
	) else $error("access bank address wrong");

	// Full move takes both whole addresses
	full_move_a: assert property (
		(decode_strobe && (s.op[15:12] == `DAO_GRP_MOVE))
		|-> (s.dec.mode == DAO_M_FULL) && (s.dec.addr == s.op[11:0])
		&& (s.dec.addr2 == s.w2[11:0])
	) else $error("full move address wrong");

	// Destination bit set writes the file
	dest_file_a: assert property (
		(decode_strobe && (s.op[15:12] >= `DAO_GRP_BYTE_LO)
		&& (s.op[15:12] <= `DAO_GRP_BYTE_HI) && s.op[`DAO_OP_D_BIT])
		|-> (s.dec.dest == DAO_D_FILE)
	) else $error("destination not the file");

	// Destination bit clear writes the accumulator
	dest_accum_a: assert property (
		(decode_strobe && (s.op[15:12] >= `DAO_GRP_BYTE_LO)
		&& (s.op[15:12] <= `DAO_GRP_BYTE_HI) && !s.op[`DAO_OP_D_BIT])
		|-> (s.dec.dest == DAO_D_ACCUM)
	) else $error("destination not the accumulator");

	// Bit ops write the addressed register
	bit_dest_a: assert property (
		(decode_strobe && (s.op[15:12] >= `DAO_GRP_BIT_LO)
		&& (s.op[15:12] <= `DAO_GRP_BIT_HI)) |-> (s.dec.dest == DAO_D_FILE)
	) else $error("bit op destination wrong");

	// Call and goto targets join both words
	jump_target_a: assert property (
		(decode_strobe && (s.op[15:12] == `DAO_GRP_JUMP)
		&& ((s.op[11:8] == `DAO_ROW_GOTO) || (s.op[11:8] == `DAO_ROW_CALL)))
		|-> (s.dec.target == {s.w2[11:0], s.op[7:0]}) && !s.dec.addr_ok
	) else $error("jump target wrong");

	// Inherent ops carry no operand
	inherent_op_a: assert property (
		(decode_strobe && (s.op[15:8] == 8'h00))
		|-> (s.dec.mode == DAO_M_INHERENT) && !s.dec.addr_ok
	) else $error("inherent op decoded with operand");

	// Constant literal ops (group 0, rows 8 to F) load the accumulator
	literal_op_a: assert property (
		(decode_strobe && (s.op[15:12] == `DAO_GRP_MISC) && s.op[11])
		|-> (s.dec.lit == s.op[7:0]) && (s.dec.dest == DAO_D_ACCUM)
	) else $error("literal op wrong");

	// Setup phase is answered in the next cycle
	apb_ready_a: assert property (
		(psel && !penable) |=> pready
	) else $error("no ready after setup");

endmodule // dao_addr

// ==== tb/dao_mem_model.sv ====
// Far-side data memory model: counts decoded accesses, keeps the last address.
// Assumes dec_out is settled whenever decode_strobe is high.
module dao_mem_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire dao_pkg::dao_dec_s dec_out,
	input wire logic decode_strobe,
	output int seen,
	output logic [11:0] last_addr
);
	timeunit 1ns;
	timeprecision 1ps;
	// Take one access for each strobe cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seen <= 0;
			last_addr <= 12'h000;
		end else if (decode_strobe) begin
			seen <= seen + 1;
			last_addr <= dec_out.addr;
		end
	end
endmodule // dao_mem_model

// ==== tb/data_operand_addressing_tb.sv ====
// Testbench for the operand addressing block, driven over APB.
// Assumes the design package and constants header are compiled first.
`include "dao_consts.svh"
module data_operand_addressing_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import dao_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic [31:0] rd; // Last read data
	logic pready;
	logic pslverr;
	logic se; // Last error flag
	logic decode_strobe;
	logic [11:0] last_addr;
	dao_dec_s dec_out;
	int error_cnt = 0;
	int checks = 0;
	int seen;
	int nops = 0; // Opcode writes issued

	dao_addr u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .dec_out(dec_out), .decode_strobe(decode_strobe));
	dao_mem_model u_mem (.pclk(pclk), .presetn(presetn), .dec_out(dec_out),
		.decode_strobe(decode_strobe), .seen(seen), .last_addr(last_addr));

	// 125 MHz clock
	initial begin
		forever #4 pclk = ~pclk;
	end

	// Value compare
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask

	// One APB transfer; waits for pready, only the watchdog ends a hang
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Opcode write, then strobe and mode check; mode 7 skips the mode
	task dec(input logic [15:0] op, input logic [2:0] m);
		apb(1'b1, `DAO_OFF_OPCODE, {16'h0000, op});
		nops++;
		#1;
		chk("strobe", 32'h1, decode_strobe);
		if (m != 3'h7) chk("mode", m, dec_out.mode);
	endtask

	// Closing report
	task results;
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Watchdog
	initial begin
		#100000;
		error_cnt++;
		results;
	end

	// Main sequence
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `DAO_OFF_RESULT, 32'h0);
		chk("result rst", 32'h0, rd);
		apb(1'b1, `DAO_OFF_CTRL, 32'h3);
		apb(1'b0, `DAO_OFF_CTRL, 32'h0);
		chk("ctrl", 32'h3, rd);
		apb(1'b0, 8'h40, 32'h0);
		chk("slverr", 32'h1, se);
		chk("unmapped", 32'h0, rd);
		dec(16'h1350, DAO_M_BANKED);
		chk("addr", 32'h350, dec_out.addr);
		chk("dest", DAO_D_FILE, dec_out.dest);
		apb(1'b0, `DAO_OFF_RESULT, 32'h0);
		chk("res word", 32'h0005_2350, rd);
		@(posedge pclk);
		#1;
		chk("strobe off", 32'h0, decode_strobe);
		dec(16'h1050, DAO_M_ACCESS);
		chk("addr", 32'h050, dec_out.addr);
		chk("dest", DAO_D_ACCUM, dec_out.dest);
		dec(16'h10A0, DAO_M_ACCESS);
		chk("addr", 32'hFA0, dec_out.addr);
		dec(16'h0864, DAO_M_LITERAL);
		chk("lit", 32'h64, dec_out.lit);
		chk("dest", DAO_D_ACCUM, dec_out.dest);
		apb(1'b0, `DAO_OFF_LITERAL, 32'h0);
		chk("lit rd", 32'h64, rd);
		dec(16'h0000, DAO_M_INHERENT);
		chk("ok", 32'h0, dec_out.addr_ok);
		dec(16'h6150, DAO_M_BANKED);
		chk("dest", DAO_D_FILE, dec_out.dest);
		apb(1'b1, `DAO_OFF_WORD2, 32'h123);
		dec(16'hC456, DAO_M_FULL);
		chk("addr", 32'h456, dec_out.addr);
		chk("addr2", 32'h123, dec_out.addr2);
		apb(1'b1, `DAO_OFF_WORD2, 32'hABC);
		dec(16'hEC12, 3'h7);
		chk("target", 32'hABC12, dec_out.target);
		apb(1'b1, `DAO_OFF_TARGET, 32'hFFFF_FFFF);
		apb(1'b0, `DAO_OFF_TARGET, 32'h0);
		chk("target ro", 32'hABC12, rd);
		apb(1'b1, `DAO_OFF_INDEX, 32'h200);
		apb(1'b1, `DAO_OFF_CTRL, 32'h103);
		dec(16'h1020, DAO_M_INDEXED);
		chk("addr", 32'h220, dec_out.addr);
		dec(16'h1320, DAO_M_BANKED);
		chk("addr", 32'h320, dec_out.addr);
		apb(1'b0, `DAO_OFF_INDEX, 32'h0);
		chk("index rd", 32'h200, rd);
		dec(16'h0105, DAO_M_LITERAL);
		chk("lit", 32'h05, dec_out.lit);
		chk("dest", DAO_D_NONE, dec_out.dest);
		dec(16'h0250, DAO_M_INDEXED);
		chk("addr", 32'h250, dec_out.addr);
		chk("dest", DAO_D_FILE, dec_out.dest);
		dec(16'h7150, DAO_M_BANKED);
		chk("addr", 32'h350, dec_out.addr);
		chk("dest", DAO_D_FILE, dec_out.dest);
		dec(16'hEF34, 3'h7);
		chk("target", 32'hABC34, dec_out.target);
		dec(16'hD0FE, DAO_M_LITERAL);
		chk("lit", 32'hFE, dec_out.lit);
		dec(16'hF000, DAO_M_INHERENT);
		chk("ok", 32'h0, dec_out.addr_ok);
		dec(16'h1070, DAO_M_ACCESS);
		chk("addr", 32'hF70, dec_out.addr);
		repeat (2) @(posedge pclk);
		#1;
		chk("strobes", nops, seen);
		chk("mem addr", 32'hF70, last_addr);
		results;
	end
endmodule // data_operand_addressing_tb
